// ---- verilog/ddsl_core.sv ----
/*
  ddsl_core: device side of a dual dac serial load interface with an
  avalon-mm register slave. Pins come from outside and are synchronised;
  the serial clock must be well below a quarter of ref_clk_i.
*/
// Contract
// - a falling load strobe copies both input registers into the dac registers.
// - with the load strobe held low in standalone mode the dac updates from the 16th edge's word.
// - with the load strobe held low in daisy-chain mode the dac updates at frame select rising.
// - after reset data is sampled on falling clock edges, and a config word can pick rising.
// - a 16-bit shift register takes one serial bit per active clock edge.
// - the serial output changes on the edge opposite the sampling edge.
// - after a readback word four zero bits and then the dac register go out over the 16 output edges of the next frame.
// - frame select low enables the shift register, which captures on following active edges.
// - in standalone mode active edges are counted and the word latches on the 16th.
// - in daisy-chain mode shifted data emerges on the serial output for the next device.
// - the clear input resets input and dac registers to zero or midscale as configured.
`timescale 1ns/1ns
module ddsl_core
  import ddsl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic frame_sel_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  input wire logic load_strobe_n_i,
  input wire logic async_clear_n_i,
  // dac codes
  output logic [DAC_BITS-1:0] dac_a_o,
  output logic [DAC_BITS-1:0] dac_b_o,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  localparam int NPIN = 5;
  localparam int LW = $clog2(FIFO_DEPTH+1);

  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic sclk_d_reg;
  logic sync_d_reg;
  logic load_strobe_n_d_reg;
  logic sclk_s, sync_n_s, sin_s, load_strobe_n_n_s, clr_n_s;
  logic sclk_rise, sclk_fall, act_edge, out_edge;
  logic sync_fall, sync_rise, load_strobe_n_fall;

  logic [WORD_BITS-1:0] shift_reg;
  logic [CNT_BITS-1:0] cnt_reg;
  logic frame_reg;
  logic word_done;
  ddsl_word_t word_in;
  logic serial_out_reg;
  logic [DAC_BITS-1:0] rb_shift_reg;
  logic [CNT_BITS-1:0] rb_cnt_reg;
  logic rb_arm_reg;
  logic [DAC_BITS-1:0] rb_val_reg;

  ddsl_cfg_t cfg_reg;
  logic [DAC_BITS-1:0] in_a_reg, in_b_reg, dac_a_reg, dac_b_reg;
  logic [DAC_BITS-1:0] clr_val;

  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  ddsl_word_t fifo_out;
  logic [LW-1:0] fifo_level;
  logic overrun_reg;
  logic [31:0] ctrl_reg;
  logic hold_decode;

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic bus_req, wr_fire, rd_load;

  // every pin is a foreign level: two flops before any logic reads it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 5'h1B;
      pin_sync_reg <= 5'h1B;
    end else begin
      pin_meta_reg <= {async_clear_n_i, load_strobe_n_i, serial_in_i, frame_sel_n_i,
                       shift_clk_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign {clr_n_s, load_strobe_n_n_s, sin_s, sync_n_s, sclk_s} = pin_sync_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      // idle level of the clock pin, so no false edge follows reset
      sclk_d_reg <= 1'b1;
      sync_d_reg <= 1'b1;
      load_strobe_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_n_s;
      load_strobe_n_d_reg <= load_strobe_n_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign act_edge = cfg_reg.rise_edge ? sclk_rise : sclk_fall;
  assign out_edge = cfg_reg.rise_edge ? sclk_fall : sclk_rise;
  assign sync_fall = ~sync_n_s & sync_d_reg;
  assign sync_rise = sync_n_s & ~sync_d_reg;
  assign load_strobe_n_fall = ~load_strobe_n_n_s & load_strobe_n_d_reg;

  // input shift register and edge counter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !clr_n_s) begin
      shift_reg <= '0;
      cnt_reg <= '0;
      frame_reg <= 1'b0;
    end else if (sync_fall) begin
      cnt_reg <= '0;
      frame_reg <= 1'b1;
    end else if (sync_rise) begin
      frame_reg <= 1'b0;
    end else if (frame_reg && !sync_n_s && act_edge) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], sin_s};
      if (cnt_reg != RB_EDGES) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // standalone latches on the 16th active edge, daisy-chain at frame end
  always_comb begin
    word_done = 1'b0;
    word_in = shift_reg;
    if (cfg_reg.daisy) begin
      word_done = frame_reg & sync_rise;
    end else if (frame_reg && !sync_n_s && act_edge && cnt_reg == FRAME_LAST) begin
      word_done = 1'b1;
      word_in = {shift_reg[WORD_BITS-2:0], sin_s};
    end
  end

  // a full fifo drops the word; software sees it as overrun
  ddsl_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(word_done),
    .in_ready_o(fifo_in_ready),
    .in_data_i(word_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(~hold_decode),
    .out_data_o(fifo_out),
    .level_o(fifo_level)
  );

  assign hold_decode = ctrl_reg[0];
  assign fifo_pop = fifo_out_valid & ~hold_decode;
  assign clr_val = cfg_reg.mid_clear ? MID_SCALE : ZERO_SCALE;

  // command decode, input and dac registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= CFG_RESET;
      in_a_reg <= ZERO_SCALE;
      in_b_reg <= ZERO_SCALE;
      dac_a_reg <= ZERO_SCALE;
      dac_b_reg <= ZERO_SCALE;
    end else if (!clr_n_s) begin
      in_a_reg <= clr_val;
      in_b_reg <= clr_val;
      dac_a_reg <= clr_val;
      dac_b_reg <= clr_val;
    end else begin
      if (load_strobe_n_fall) begin
        dac_a_reg <= in_a_reg;
        dac_b_reg <= in_b_reg;
      end
      if (fifo_pop) begin
        case (fifo_out.cmd)
          CMD_WR_A: begin
            in_a_reg <= fifo_out.data;
            if (!load_strobe_n_n_s) begin
              dac_a_reg <= fifo_out.data;
            end
          end
          CMD_WR_B: begin
            in_b_reg <= fifo_out.data;
            if (!load_strobe_n_n_s) begin
              dac_b_reg <= fifo_out.data;
            end
          end
          CMD_CFG: begin
            cfg_reg.rise_edge <= fifo_out.data[CFG_RISE_POS];
            cfg_reg.daisy <= fifo_out.data[CFG_DAISY_POS];
            cfg_reg.mid_clear <= fifo_out.data[CFG_MID_POS];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // readback request is armed at decode and loaded at the next frame start
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !clr_n_s) begin
      rb_arm_reg <= 1'b0;
      rb_val_reg <= '0;
    end else if (fifo_pop && (fifo_out.cmd == CMD_RB_A || fifo_out.cmd == CMD_RB_B)) begin
      rb_arm_reg <= 1'b1;
      rb_val_reg <= (fifo_out.cmd == CMD_RB_A) ? dac_a_reg : dac_b_reg;
    end else if (sync_fall) begin
      rb_arm_reg <= 1'b0;
    end
  end

  // serial output: chained shift data, or dac contents during readback
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !clr_n_s) begin
      serial_out_reg <= 1'b0;
      rb_shift_reg <= '0;
      rb_cnt_reg <= '0;
    end else if (sync_fall && rb_arm_reg) begin
      rb_shift_reg <= rb_val_reg;
      rb_cnt_reg <= RB_EDGES;
    end else if (frame_reg && out_edge) begin
      if (rb_cnt_reg != '0) begin
        serial_out_reg <= (rb_cnt_reg > 5'(DAC_BITS)) ? 1'b0 : rb_shift_reg[DAC_BITS-1];
        if (rb_cnt_reg <= 5'(DAC_BITS)) begin
          rb_shift_reg <= {rb_shift_reg[DAC_BITS-2:0], 1'b0};
        end
        rb_cnt_reg <= rb_cnt_reg - 1'b1;
      end else begin
        serial_out_reg <= shift_reg[WORD_BITS-1];
      end
    end
  end

  // avalon slave: one wait cycle, answer at the second edge
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign wr_fire = avs_write_i & ack_reg;
  assign rd_load = avs_read_i & ~ack_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
      ctrl_reg <= {24'h000000, 7'h00, avs_writedata_i[0]};
    end
  end

  // a new overrun in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      overrun_reg <= 1'b0;
    end else if (word_done && !fifo_in_ready) begin
      overrun_reg <= 1'b1;
    end else if (wr_fire && avs_address_i == OFS_STATUS && avs_byteenable_i[0] &&
                 avs_writedata_i[ST_OVR_POS]) begin
      overrun_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_load) begin
      rdata_reg <= 32'h0000_0000;
      case (avs_address_i)
        OFS_CTRL: rdata_reg <= ctrl_reg;
        OFS_STATUS: begin
          rdata_reg[ST_RISE_POS] <= cfg_reg.rise_edge;
          rdata_reg[ST_DAISY_POS] <= cfg_reg.daisy;
          rdata_reg[ST_MID_POS] <= cfg_reg.mid_clear;
          rdata_reg[ST_OVR_POS] <= overrun_reg;
          rdata_reg[ST_RB_POS] <= (rb_cnt_reg != '0) | rb_arm_reg;
          rdata_reg[ST_LVL_POS +: LW] <= fifo_level;
        end
        OFS_DAC_A: rdata_reg[DAC_BITS-1:0] <= dac_a_reg;
        OFS_DAC_B: rdata_reg[DAC_BITS-1:0] <= dac_b_reg;
        OFS_IN_A: rdata_reg[DAC_BITS-1:0] <= in_a_reg;
        OFS_IN_B: rdata_reg[DAC_BITS-1:0] <= in_b_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign serial_out_o = serial_out_reg;
  assign dac_a_o = dac_a_reg;
  assign dac_b_o = dac_b_reg;
endmodule : ddsl_core

// ---- verilog/ddsl_pkg.sv ----
/*
  ddsl_pkg: shared constants and types of the dual dac serial load interface.
  Assumes it is compiled before every module that imports it.
*/
package ddsl_pkg;
  localparam int WORD_BITS = 16;
  localparam int DAC_BITS = 12;
  localparam int CMD_BITS = 4;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] FRAME_LAST = 5'h0F;
  localparam logic [CNT_BITS-1:0] RB_EDGES = 5'h10;
  localparam int FIFO_DEPTH = 4;

  // command codes in the top nibble of a serial word
  localparam logic [CMD_BITS-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_BITS-1:0] CMD_WR_A = 4'h1;
  localparam logic [CMD_BITS-1:0] CMD_WR_B = 4'h2;
  localparam logic [CMD_BITS-1:0] CMD_RB_A = 4'h3;
  localparam logic [CMD_BITS-1:0] CMD_RB_B = 4'h4;
  localparam logic [CMD_BITS-1:0] CMD_CFG = 4'h5;

  // configuration bits carried in the data field of CMD_CFG
  localparam int CFG_RISE_POS = 0;
  localparam int CFG_DAISY_POS = 1;
  localparam int CFG_MID_POS = 2;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_DAC_A = 5'h08;
  localparam logic [4:0] OFS_DAC_B = 5'h0C;
  localparam logic [4:0] OFS_IN_A = 5'h10;
  localparam logic [4:0] OFS_IN_B = 5'h14;

  // status field positions
  localparam int ST_RISE_POS = 0;
  localparam int ST_DAISY_POS = 1;
  localparam int ST_MID_POS = 2;
  localparam int ST_OVR_POS = 3;
  localparam int ST_RB_POS = 4;
  localparam int ST_LVL_POS = 8;

  localparam logic [DAC_BITS-1:0] ZERO_SCALE = 12'h000;
  localparam logic [DAC_BITS-1:0] MID_SCALE = 12'h800;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [CMD_BITS-1:0] cmd;
    logic [DAC_BITS-1:0] data;
  } ddsl_word_t;

  typedef struct packed {
    logic mid_clear;
    logic daisy;
    logic rise_edge;
  } ddsl_cfg_t;

  localparam ddsl_cfg_t CFG_RESET = 3'h0;
endpackage : ddsl_pkg

// ---- verilog/ddsl_fifo.sv ----
/*
  ddsl_fifo: small valid/ready fifo for received serial words.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module ddsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [LW-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready_o = (level_reg != LW'(DEPTH));
  assign out_valid_o = (level_reg != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign level_o = level_reg;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end
endmodule : ddsl_fifo

// ---- bench/ddsl_core_assertions.sv ----
/*
  ddsl_core_checker: port-level assertions for ddsl_core, bound to every instance.
  Assumes one clock domain on ref_clk_i and a synchronous active-low rst_n_i.
*/
`timescale 1ns/1ns
module ddsl_core_checker
  import ddsl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic frame_sel_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic load_strobe_n_i,
  input wire logic async_clear_n_i,
  // dac codes
  input wire logic [DAC_BITS-1:0] dac_a_o,
  input wire logic [DAC_BITS-1:0] dac_b_o,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] pins_reg;
  logic [3:0] quiet_reg;
  // the pins are synchronised, so the output may lag a pin edge by a few cycles, never more
  always_ff @(posedge ref_clk_i) begin
    pins_reg <= {shift_clk_i, frame_sel_n_i, async_clear_n_i};
    if (!rst_n_i || pins_reg != {shift_clk_i, frame_sel_n_i, async_clear_n_i}) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  a_wait_one_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest held past one wait state");
  a_wait_first: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i) &&
    !$past(avs_write_i) |-> avs_waitrequest_o) else $error("new request not stalled");
  a_wait_needs_req: assert property (avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("waitrequest without a request");
  a_rd_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("readdata moved without a read");
  a_clear_value: assert property (!async_clear_n_i [*4] |=> dac_a_o == dac_b_o &&
    (dac_a_o == ZERO_SCALE || dac_a_o == MID_SCALE)) else $error("clear left a wrong code");
  a_dac_hold: assert property ((load_strobe_n_i && async_clear_n_i) [*6]
    |=> $stable(dac_a_o) && $stable(dac_b_o)) else $error("dac moved with strobe high");
  a_frame_idle_out: assert property ((frame_sel_n_i && async_clear_n_i) [*6]
    |=> $stable(serial_out_o)) else $error("serial out moved outside a frame");
  a_sout_quiet: assert property (quiet_reg > 4'h6 |-> $stable(serial_out_o))
    else $error("serial out moved away from a clock edge");
endmodule : ddsl_core_checker

bind ddsl_core ddsl_core_checker chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .frame_sel_n_i(frame_sel_n_i), .shift_clk_i(shift_clk_i), .serial_in_i(serial_in_i),
  .serial_out_o(serial_out_o), .load_strobe_n_i(load_strobe_n_i),
  .async_clear_n_i(async_clear_n_i), .dac_a_o(dac_a_o), .dac_b_o(dac_b_o),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

// ---- bench/ddsl_host_model.sv ----
/*
  ddsl_host_model: host serial controller, one 16-bit word per frame, 80 ns clock.
  Assumes the caller picks the sampling edge that the device is set to.
*/
`timescale 1ns/1ns
module ddsl_host_model (
  // serial pins
  output logic frame_sel_n_o,
  output logic shift_clk_o,
  output logic serial_in_o,
  input wire logic serial_out_i
);
  initial begin
    frame_sel_n_o = 1'b1;
    shift_clk_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // rx: output seen before each active edge, then once after the last output edge
  task automatic xfer(input logic [15:0] tx, input logic rise, output logic [16:0] rx);
    #(10 - $time % 10);
    shift_clk_o = ~rise; // clock stands still at idle between frames
    #40 frame_sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in_o = tx[i];
      #38 rx = {rx[15:0], serial_out_i};
      #2 shift_clk_o = rise;
      #40 shift_clk_o = ~rise;
    end
    #38 rx = {rx[15:0], serial_out_i};
    #2 frame_sel_n_o = 1'b1;
    serial_in_o = ~tx[0]; // a released data line keeps no value
    #60;
  endtask : xfer
endmodule : ddsl_host_model

// ---- bench/ddsl_core_tb_top.sv ----
/*
  ddsl_core_tb_top: self-checking bench for ddsl_core driven by a host serial model.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ns
module ddsl_core_tb_top
  import ddsl_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic load_strobe_n_i = 1'b1;
  logic async_clear_n_i = 1'b1;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic frame_sel_n, shift_clk, serial_in, serial_out, avs_waitrequest;
  logic [DAC_BITS-1:0] dac_a, dac_b;
  logic [31:0] avs_readdata, bus_rd;
  logic [16:0] rx;
  int n_errors = 0;
  int n_compared = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  ddsl_host_model host_u (.frame_sel_n_o(frame_sel_n), .shift_clk_o(shift_clk),
    .serial_in_o(serial_in), .serial_out_i(serial_out));
  ddsl_core dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .frame_sel_n_i(frame_sel_n),
    .shift_clk_i(shift_clk), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .load_strobe_n_i(load_strobe_n_i), .async_clear_n_i(async_clear_n_i),
    .dac_a_o(dac_a), .dac_b_o(dac_b), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask : rd_chk
  task automatic wait_dacs(input logic [11:0] ea, input logic [11:0] eb);
    for (int i = 0; i < 40 && !(dac_a === ea && dac_b === eb); i++) @(posedge ref_clk_i);
    check(32'(dac_a), 32'(ea));
    check(32'(dac_b), 32'(eb));
  endtask : wait_dacs
  task automatic t_reset();
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_CTRL, CTRL_RESET);
    bus(1'b1, 5'h18, 32'hFFFF_FFFF, bus_rd);
    rd_chk(5'h18, 32'h0000_0000);
    wait_dacs(ZERO_SCALE, ZERO_SCALE);
    $display("test reset done");
  endtask : t_reset
  task automatic t_async();
    host_u.xfer({CMD_WR_A, 12'h123}, 1'b0, rx);
    host_u.xfer({CMD_WR_B, 12'h456}, 1'b0, rx);
    repeat (20) @(posedge ref_clk_i);
    wait_dacs(12'h000, 12'h000);
    rd_chk(OFS_IN_A, 32'h0000_0123);
    rd_chk(OFS_IN_B, 32'h0000_0456);
    @(posedge ref_clk_i) load_strobe_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    load_strobe_n_i <= 1'b1;
    wait_dacs(12'h123, 12'h456);
    $display("test async update done");
  endtask : t_async
  task automatic t_sync();
    @(posedge ref_clk_i) load_strobe_n_i <= 1'b0;
    host_u.xfer({CMD_WR_B, 12'hABC}, 1'b0, rx);
    wait_dacs(12'h123, 12'hABC);
    @(posedge ref_clk_i) load_strobe_n_i <= 1'b1;
    $display("test sync update done");
  endtask : t_sync
  task automatic t_fifo();
    bus(1'b1, OFS_CTRL, 32'h0000_0001, bus_rd);
    for (int k = 1; k <= 5; k++) host_u.xfer({CMD_WR_A, 12'(k)}, 1'b0, rx);
    rd_chk(OFS_STATUS, 32'h0000_0408);
    bus(1'b1, OFS_CTRL, 32'h0000_0000, bus_rd);
    bus(1'b1, OFS_STATUS, 32'h0000_0008, bus_rd);
    // four queued words drain one per cycle
    repeat (8) @(posedge ref_clk_i);
    rd_chk(OFS_IN_A, 32'h0000_0004);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    $display("test fifo full done");
  endtask : t_fifo
  task automatic t_readback();
    host_u.xfer({CMD_RB_A, 12'h000}, 1'b0, rx);
    host_u.xfer({CMD_RB_B, 12'h000}, 1'b0, rx);
    check(32'(rx[15:0]), 32'h0000_0123);
    rd_chk(OFS_STATUS, 32'h0000_0010);
    host_u.xfer({CMD_NOP, 12'h000}, 1'b0, rx);
    check(32'(rx[15:0]), 32'h0000_0ABC);
    $display("test readback done");
  endtask : t_readback
  task automatic t_daisy();
    host_u.xfer({CMD_CFG, 12'h007}, 1'b0, rx);
    rd_chk(OFS_STATUS, 32'h0000_0007);
    @(posedge ref_clk_i) load_strobe_n_i <= 1'b0;
    host_u.xfer({CMD_WR_A, 12'h456}, 1'b1, rx);
    wait_dacs(12'h456, 12'hABC);
    host_u.xfer({CMD_NOP, 12'h000}, 1'b1, rx);
    check(32'(rx[16:1]), {16'h0000, CMD_WR_A, 12'h456});
    $display("test daisy chain done");
  endtask : t_daisy
  task automatic t_clear();
    @(posedge ref_clk_i) async_clear_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    async_clear_n_i <= 1'b1;
    wait_dacs(MID_SCALE, MID_SCALE);
    rd_chk(OFS_IN_A, 32'h0000_0800);
    rd_chk(OFS_STATUS, 32'h0000_0007);
    $display("test clear done");
  endtask : t_clear
  initial begin
    #100_000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_async();
    t_sync();
    t_fifo();
    t_readback();
    t_daisy();
    t_clear();
    report_and_stop();
  end
endmodule : ddsl_core_tb_top
